// ### inc/cfb_pkg.sv
// Shared types and constants for the flag and branch execution unit.
package cfb_pkg;

  // Status register bit positions.
  localparam int unsigned CFB_SR_C         = 0;
  localparam int unsigned CFB_SR_Z         = 1;
  localparam int unsigned CFB_SR_N         = 2;
  localparam int unsigned CFB_SR_IRQ_ALLOW = 3;
  localparam int unsigned CFB_SR_HALT      = 4;
  localparam int unsigned CFB_SR_OSCDIS    = 5;
  localparam int unsigned CFB_SR_V         = 8;

  // Constant ORed into the status register by the allow operation.
  localparam logic [15:0] CFB_IRQ_ALLOW_MASK = 16'h0008;
  localparam logic [15:0] CFB_SR_RST         = 16'h0000;
  localparam logic [19:0] CFB_PC_RST         = 20'h00000;

  // Operand constants.
  localparam logic [15:0] CFB_W_ONES  = 16'hFFFF;
  localparam logic [15:0] CFB_W_FFFE  = 16'hFFFE;
  localparam logic [15:0] CFB_W_7FFF  = 16'h7FFF;
  localparam logic [15:0] CFB_W_7FFE  = 16'h7FFE;
  localparam logic [7:0]  CFB_B_ONES  = 8'hFF;
  localparam logic [7:0]  CFB_B_FE    = 8'hFE;
  localparam logic [7:0]  CFB_B_7F    = 8'h7F;
  localparam logic [7:0]  CFB_B_7E    = 8'h7E;
  localparam logic [15:0] CFB_ONE     = 16'h0001;
  localparam logic [15:0] CFB_TWO     = 16'h0002;

  // Register byte addresses.
  localparam logic [7:0] CFB_REG_SR     = 8'h00;
  localparam logic [7:0] CFB_REG_PC     = 8'h04;
  localparam logic [7:0] CFB_REG_RESULT = 8'h08;
  localparam logic [7:0] CFB_REG_INFO   = 8'h0C;

  // Default widths.
  localparam int unsigned CFB_PC_W   = 20;
  localparam int unsigned CFB_OFFS_W = 10;

  typedef enum logic [2:0] {
    CFB_INC,
    CFB_ADD_TWO_OP,
    CFB_BITWISE_NOT_OP,
    CFB_IRQ_ALLOW_OP,
    CFB_BRANCH_ON_CARRY,
    CFB_BRANCH_ON_ZERO_FLAG,
    CFB_BRANCH_SIGNED_NOT_BELOW
  } cfb_op_t;

  // One instruction as handed to the unit.
  typedef struct packed {
    logic        valid;
    cfb_op_t     op;
    logic        byte_form;
    logic [15:0] dst;
    logic [9:0]  offset;
  } cfb_insn_t;

  // Plain register port request.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } cfb_bus_t;

endpackage : cfb_pkg

// ### core/cfb_exec.sv
// Flag and branch execution unit of the 16-bit core.
//
// Contract
// (RULE_01) Interrupt allow ORs 0008h into the status register, flags kept.
// (RULE_02) The single instruction after interrupt allow always executes first.
// (RULE_03) Program code keeps one instruction between allowing and blocking.
// (RULE_04) Interrupt allow keeps the oscillator-disable and halt bits.
// (RULE_05) Increment adds one to the word or byte destination.
// (RULE_06) Increment zero flag set when destination held FFFFh or FFh.
// (RULE_07) Word increment carry set only when destination was FFFFh.
// (RULE_08) Increment overflow set only for 7FFFh or 7Fh destinations.
// (RULE_09) Increment, add two, invert set negative from result sign.
// (RULE_10) Add two adds two to the word or byte destination.
// (RULE_11) Add two zero flag set only for FFFEh or FEh destinations.
// (RULE_12) Add two carry set for FFFEh, FFFFh, FEh or FFh destinations.
// (RULE_13) Word add two overflow set for 7FFEh or 7FFFh destinations.
// (RULE_14) Invert is exclusive-OR with FFFFh or FFh, written back.
// (RULE_15) Invert carry equals the complement of the zero flag.
// (RULE_16) Invert overflow set when the original destination was negative.
// (RULE_17) Arithmetic and jumps keep oscillator, halt and interrupt bits.
// (RULE_18) Carry jump adds the doubled sign-extended offset to the counter.
// (RULE_19) A false jump condition proceeds with the following instruction.
// (RULE_20) Taken jumps reach -511 to +512 words anywhere in memory.
// (RULE_21) Zero jump branches when zero is set, falls through otherwise.
// (RULE_22) Signed not-below jump branches when negative equals overflow.
// (RULE_23) Conditional jumps change no arithmetic status flag.
// (RULE_24) Byte forms take flags from the low eight bits, bit 7 sign.
module cfb_exec
  import cfb_pkg::*;
#(
  parameter int unsigned PC_W   = cfb_pkg::CFB_PC_W,
  parameter int unsigned OFFS_W = cfb_pkg::CFB_OFFS_W
) (
  // Clock and reset.
  input  wire logic                core_clk,
  input  wire logic                rstn,
  // Instruction stream.
  input  cfb_pkg::cfb_insn_t       insn,
  input  wire logic                other_retire,
  // Interrupt request from the controller.
  input  wire logic                irq_pending,
  // Register port.
  input  cfb_pkg::cfb_bus_t        bus,
  output logic [31:0]              rdata,
  // Execution results.
  output logic                     res_valid,
  output logic [15:0]              res_data,
  output logic                     branch_taken,
  output logic [PC_W-1:0]          pc,
  output logic [15:0]              sr,
  output logic                     irq_take
);
  import cfb_pkg::*;

  // The read port packs the counter into a fixed 32-bit word.
  if (PC_W != CFB_PC_W || OFFS_W != CFB_OFFS_W)
  begin : g_bad_width
    $error("cfb_exec serves a 20-bit counter and 10-bit offsets only.");
  end

  typedef struct packed {
    logic [15:0]     sr;
    logic [PC_W-1:0] pc;
    logic [15:0]     result;
    logic            res_valid;
    logic            branch_taken;
    logic            irq_take;
    logic            shadow;
    logic [31:0]     rdata;
  } cfb_state_t;

  cfb_state_t state;
  cfb_state_t next_state;

  // Reset release through two flip-flops.
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  always_comb
  begin
    logic [15:0]     sr_v;
    logic [15:0]     res;
    logic [PC_W-1:0] disp;
    logic            is_arith;
    logic            is_jump;
    logic            cond;
    logic            z;
    logic            c;
    logic            v;
    logic            n;

    next_state = state;
    next_state.res_valid    = 1'b0;
    next_state.branch_taken = 1'b0;
    next_state.rdata        = 32'h00000000;
    sr_v     = state.sr;
    res      = 16'h0000;
    disp     = {{(PC_W-OFFS_W-1){insn.offset[OFFS_W-1]}}, insn.offset, 1'b0};
    is_arith = 1'b0;
    is_jump  = 1'b0;
    cond     = 1'b0;
    z        = 1'b0;
    c        = 1'b0;
    v        = 1'b0;
    n        = 1'b0;

    // A read returns data in the following cycle only.
    if (bus.rd)
    begin
      case (bus.addr)
        CFB_REG_SR:     next_state.rdata = {16'h0000, state.sr};
        CFB_REG_PC:     next_state.rdata = {12'h000, state.pc};
        CFB_REG_RESULT: next_state.rdata = {16'h0000, state.result};
        CFB_REG_INFO:   next_state.rdata = {30'h00000000, state.irq_take,
                                            state.shadow};
        default:        next_state.rdata = 32'h00000000;
      endcase
    end

    // Software writes land first so that an instruction in the same cycle
    // sees and refines the written values.
    if (bus.wr)
    begin
      case (bus.addr)
        CFB_REG_SR: sr_v = bus.wdata[15:0];
        CFB_REG_PC: next_state.pc = bus.wdata[PC_W-1:0];
        default:    ;
      endcase
    end

    if (insn.valid)
    begin
      case (insn.op)
        CFB_INC:
        begin
          is_arith = 1'b1;
          res = insn.dst + CFB_ONE; // RULE_05
          if (insn.byte_form)
          begin
            z = (insn.dst[7:0] == CFB_B_ONES); // RULE_06 RULE_24
            c = (insn.dst[7:0] == CFB_B_ONES); // RULE_24
            v = (insn.dst[7:0] == CFB_B_7F);   // RULE_08
          end
          else
          begin
            z = (insn.dst == CFB_W_ONES); // RULE_06
            c = (insn.dst == CFB_W_ONES); // RULE_07
            v = (insn.dst == CFB_W_7FFF); // RULE_08
          end
        end
        CFB_ADD_TWO_OP:
        begin
          is_arith = 1'b1;
          res = insn.dst + CFB_TWO; // RULE_10
          if (insn.byte_form)
          begin
            z = (insn.dst[7:0] == CFB_B_FE); // RULE_11
            c = (insn.dst[7:0] >= CFB_B_FE); // RULE_12
            v = (insn.dst[7:1] == CFB_B_7E[7:1]); // RULE_24
          end
          else
          begin
            z = (insn.dst == CFB_W_FFFE); // RULE_11
            c = (insn.dst >= CFB_W_FFFE); // RULE_12
            v = (insn.dst[15:1] == CFB_W_7FFE[15:1]); // RULE_13
          end
        end
        CFB_BITWISE_NOT_OP:
        begin
          is_arith = 1'b1;
          res = insn.dst ^ CFB_W_ONES; // RULE_14
          if (insn.byte_form)
          begin
            z = (insn.dst[7:0] == CFB_B_ONES);
            v = insn.dst[7]; // RULE_16 RULE_24
          end
          else
          begin
            z = (insn.dst == CFB_W_ONES);
            v = insn.dst[15]; // RULE_16
          end
          c = ~z; // RULE_15
        end
        CFB_IRQ_ALLOW_OP:
        begin
          // Only the allow bit moves; halt and oscillator bits stay.
          sr_v = sr_v | CFB_IRQ_ALLOW_MASK; // RULE_01 RULE_04
        end
        CFB_BRANCH_ON_CARRY:
        begin
          is_jump = 1'b1;
          cond = sr_v[CFB_SR_C]; // RULE_18
        end
        CFB_BRANCH_ON_ZERO_FLAG:
        begin
          is_jump = 1'b1;
          cond = sr_v[CFB_SR_Z]; // RULE_21
        end
        CFB_BRANCH_SIGNED_NOT_BELOW:
        begin
          is_jump = 1'b1;
          cond = (sr_v[CFB_SR_N] == sr_v[CFB_SR_V]); // RULE_22
        end
        default: ;
      endcase

      if (is_arith)
      begin
        if (insn.byte_form)
        begin
          res = {8'h00, res[7:0]}; // RULE_24
          n   = res[7];
        end
        else
        begin
          n = res[15]; // RULE_09
        end
        // Only the four arithmetic flags change here.
        sr_v[CFB_SR_C] = c; // RULE_17
        sr_v[CFB_SR_Z] = z;
        sr_v[CFB_SR_N] = n;
        sr_v[CFB_SR_V] = v;
        next_state.result    = res;
        next_state.res_valid = 1'b1;
      end

      // The counter already points past the jump, so a false condition
      // simply leaves it there and a true one adds the doubled offset.
      if (is_jump && cond)
      begin
        next_state.pc = next_state.pc + disp; // RULE_18 RULE_20
        next_state.branch_taken = 1'b1;
      end
      // A not-taken jump keeps the counter on the next instruction. RULE_19
      // Status flags pass through jumps untouched. RULE_23
    end

    // The instruction following interrupt allow is protected; any other
    // retiring instruction ends that protection.
    if (insn.valid && insn.op == CFB_IRQ_ALLOW_OP)
    begin
      next_state.shadow = 1'b1; // RULE_02
    end
    else if (insn.valid || other_retire)
    begin
      next_state.shadow = 1'b0;
    end

    next_state.irq_take = irq_pending && sr_v[CFB_SR_IRQ_ALLOW] &&
                          !next_state.shadow; // RULE_02
    next_state.sr = sr_v;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= '{sr: CFB_SR_RST, pc: CFB_PC_RST, default: '0};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rdata        = state.rdata;
  assign res_valid    = state.res_valid;
  assign res_data     = state.result;
  assign branch_taken = state.branch_taken;
  assign pc           = state.pc;
  assign sr           = state.sr;
  assign irq_take     = state.irq_take;

  // Checks on the driven results.
  chk_allow_sets_bit: assert property ( // RULE_01
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && insn.op == CFB_IRQ_ALLOW_OP |=> sr[CFB_SR_IRQ_ALLOW])
    else $error("Allow operation did not set the interrupt bit.");

  chk_allow_keeps_bits: assert property ( // RULE_04
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && insn.op == CFB_IRQ_ALLOW_OP && !bus.wr
    |=> sr[15:4] == $past(sr[15:4]) && sr[2:0] == $past(sr[2:0]))
    else $error("Allow operation disturbed other status bits.");

  chk_shadow_blocks_irq: assert property ( // RULE_02
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && insn.op == CFB_IRQ_ALLOW_OP |=> !irq_take)
    else $error("Interrupt taken before the protected instruction.");

  chk_inc_result: assert property ( // RULE_05
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && insn.op == CFB_INC && !insn.byte_form
    |=> res_valid && res_data == $past(insn.dst) + 16'h0001)
    else $error("Increment result wrong.");

  chk_inc_flags: assert property ( // RULE_07
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && insn.op == CFB_INC && !insn.byte_form
    |=> sr[CFB_SR_C] == ($past(insn.dst) == 16'hFFFF) &&
        sr[CFB_SR_V] == ($past(insn.dst) == 16'h7FFF))
    else $error("Increment carry or overflow wrong.");

  chk_add_two_carry: assert property ( // RULE_12
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && insn.op == CFB_ADD_TWO_OP && !insn.byte_form
    |=> sr[CFB_SR_C] == ($past(insn.dst) >= 16'hFFFE))
    else $error("Add two carry wrong.");

  chk_invert_carry: assert property ( // RULE_15
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && insn.op == CFB_BITWISE_NOT_OP
    |=> sr[CFB_SR_C] == !sr[CFB_SR_Z] && res_data == ($past(insn.byte_form)
        ? {8'h00, ~$past(insn.dst[7:0])} : ~$past(insn.dst)))
    else $error("Invert carry or result wrong.");

  chk_jump_flags_kept: assert property ( // RULE_23
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && !bus.wr && (insn.op == CFB_BRANCH_ON_CARRY ||
    insn.op == CFB_BRANCH_ON_ZERO_FLAG ||
    insn.op == CFB_BRANCH_SIGNED_NOT_BELOW) |=> sr == $past(sr))
    else $error("Jump changed the status register.");

  chk_carry_jump: assert property ( // RULE_18
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && !bus.wr && insn.op == CFB_BRANCH_ON_CARRY && sr[CFB_SR_C]
    |=> branch_taken && pc == $past(pc) +
        {{9{$past(insn.offset[9])}}, $past(insn.offset), 1'b0})
    else $error("Carry jump target wrong.");

  chk_fall_through: assert property ( // RULE_19
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && !bus.wr && insn.op == CFB_BRANCH_SIGNED_NOT_BELOW &&
    sr[CFB_SR_N] != sr[CFB_SR_V] |=> !branch_taken && pc == $past(pc))
    else $error("Signed jump taken on unequal flags.");

  chk_inc_byte_flags: assert property ( // RULE_08
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && insn.op == CFB_INC && insn.byte_form
    |=> sr[CFB_SR_Z] == ($past(insn.dst[7:0]) == 8'hFF) &&
        sr[CFB_SR_V] == ($past(insn.dst[7:0]) == 8'h7F))
    else $error("Byte increment zero or overflow wrong.");

  chk_add_two_flags: assert property ( // RULE_13
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && insn.op == CFB_ADD_TWO_OP && !insn.byte_form
    |=> sr[CFB_SR_Z] == ($past(insn.dst) == 16'hFFFE) &&
        sr[CFB_SR_V] == ($past(insn.dst) == 16'h7FFE ||
                         $past(insn.dst) == 16'h7FFF))
    else $error("Add two zero or overflow wrong.");

  chk_invert_ovf: assert property ( // RULE_16
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && insn.op == CFB_BITWISE_NOT_OP
    |=> sr[CFB_SR_V] == ($past(insn.byte_form) ? $past(insn.dst[7])
                                               : $past(insn.dst[15])))
    else $error("Invert overflow wrong.");

  chk_neg_flag: assert property ( // RULE_09
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid &&
    insn.op inside {CFB_INC, CFB_ADD_TWO_OP, CFB_BITWISE_NOT_OP}
    |=> sr[CFB_SR_N] == ($past(insn.byte_form) ? res_data[7] : res_data[15]))
    else $error("Negative flag does not follow the result sign.");

  chk_zero_jump: assert property ( // RULE_21
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && !bus.wr && insn.op == CFB_BRANCH_ON_ZERO_FLAG
    |=> branch_taken == $past(sr[CFB_SR_Z]))
    else $error("Zero jump decision wrong.");

  chk_mode_bits_kept: assert property ( // RULE_17
    @(posedge core_clk) disable iff (!rst_n)
    insn.valid && !bus.wr && insn.op != CFB_IRQ_ALLOW_OP
    |=> sr[CFB_SR_OSCDIS:CFB_SR_IRQ_ALLOW] ==
        $past(sr[CFB_SR_OSCDIS:CFB_SR_IRQ_ALLOW]))
    else $error("Mode or interrupt bits changed.");

endmodule // cfb_exec

// ### tb/cfb_prog_mem.sv
// Program memory model that hands instructions to the execution unit.
module cfb_prog_mem (
  // Clock.
  input  wire logic          core_clk,
  // Fetched instruction.
  output cfb_pkg::cfb_insn_t insn
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfb_pkg::*;

  initial insn = '0;

  // One word per fetch; a nonzero gap models a slow memory.
  task automatic fetch(input cfb_op_t op, input logic bf,
                       input logic [15:0] d, input logic [9:0] o,
                       input int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    insn <= '{1'b1, op, bf, d, o};
    @(posedge core_clk);
    // Idle byte-form, destination and offset fields carry the inverse, so a stale copy is never mistaken.
    insn <= '{1'b0, op, ~bf, ~d, ~o};
  endtask
endmodule : cfb_prog_mem

// ### tb/tb_top.sv
// Self-checking bench for the flag and branch execution unit.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cfb_pkg::*;

  logic        core_clk;
  logic        rstn;
  logic        other_retire;
  logic        irq_pending;
  logic        res_valid;
  logic        branch_taken;
  logic        irq_take;
  logic [15:0] res_data;
  logic [15:0] sr;
  logic [15:0] m_sr;
  logic [19:0] pc;
  logic [19:0] m_pc;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [31:0] seed = 32'h0000_0058;
  logic [9:0]  ofs[4] = '{10'h1FF, 10'h200, 10'h001, 10'h3FF};
  logic [15:0] tbl[12] = '{16'hFFFF, 16'hFFFE, 16'h7FFF, 16'h7FFE,
    16'h00FF, 16'h00FE, 16'h007F, 16'h007E, 16'h8000, 16'h0080,
    16'h0000, 16'h1234};
  int          m_res;
  int          n_mismatch;
  int          checks;
  cfb_bus_t    bus;
  cfb_insn_t   insn;

  cfb_prog_mem i_mem (.core_clk(core_clk), .insn(insn));

  cfb_exec i_dut (.core_clk(core_clk), .rstn(rstn), .insn(insn),
    .other_retire(other_retire), .irq_pending(irq_pending), .bus(bus),
    .rdata(rdata), .res_valid(res_valid), .res_data(res_data),
    .branch_taken(branch_taken), .pc(pc), .sr(sr), .irq_take(irq_take));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge core_clk);
    bus <= '0;
    #1 d = rdata;
  endtask

  task automatic run_arith(input cfb_op_t op, input logic bf,
                           input logic [15:0] d);
    int m, s, x, r, c, z, n, v;
    m = bf ? 255 : 65535;
    s = bf ? 128 : 32768;
    x = d & m;
    r = (op == CFB_INC) ? x + 1 : (op == CFB_ADD_TWO_OP) ? x + 2 : x ^ m;
    r = r & m;
    z = (r == 0);
    n = (r >= s);
    c = (op == CFB_BITWISE_NOT_OP) ? !z : (r < x);
    v = (op == CFB_BITWISE_NOT_OP) ? (x >= s) : (x < s && r >= s);
    m_sr = (m_sr & 16'hFEF8) | 16'(c | z << 1 | n << 2 | v << 8);
    m_res = r;
    i_mem.fetch(op, bf, d, 10'(rnd()), int'(rnd() & 32'h1));
    #1;
    cmp_bit(res_valid, 1'b1);
    cmp_val(32'(res_data), 32'(r));
    cmp_bit(sr[CFB_SR_Z], z[0]);
    cmp_bit(sr[CFB_SR_C], c[0]);
    cmp_bit(sr[CFB_SR_V], v[0]);
    cmp_bit(sr[CFB_SR_N], n[0]);
    cmp_val(32'(sr), 32'(m_sr));
  endtask

  task automatic run_jump(input int j, input logic [3:0] f,
                          input logic [9:0] o, input logic [19:0] p);
    logic t;
    m_sr = {7'h00, f[3], 2'h0, 3'(rnd()), f[2:0]};
    bus_wr(CFB_REG_SR, {16'h0000, m_sr});
    bus_wr(CFB_REG_PC, {12'h000, p});
    t = (j == 0) ? f[0] : (j == 1) ? f[1] : (f[2] == f[3]);
    m_pc = t ? p + {{9{o[9]}}, o, 1'b0} : p;
    i_mem.fetch(cfb_op_t'(3'(j + 4)), 1'b0, 16'(rnd()), o, j);
    #1;
    cmp_bit(branch_taken, t);
    cmp_val(32'(pc), 32'(m_pc));
    cmp_val(32'(sr), 32'(m_sr));
  endtask

  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    $display("Error at %0t: run did not finish", $time);
    close_out();
  end

  initial
  begin
    rstn = 1'b0;
    bus = '0;
    irq_pending = 1'b0;
    other_retire = 1'b0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    cmp_val(32'(sr), 32'(CFB_SR_RST));
    cmp_val(32'(pc), 32'(CFB_PC_RST));
    for (int i = 0; i < 32; i++)
      for (int k = 0; k < 6; k++)
      begin
        m_sr = 16'(rnd()) & 16'h013F;
        bus_wr(CFB_REG_SR, {16'h0000, m_sr});
        run_arith(cfb_op_t'(3'(k >> 1)), k[0], i < 12 ? tbl[i] : 16'(rnd()));
      end
    bus_wr(CFB_REG_RESULT, 32'hFFFF_FFFF);
    bus_rd(CFB_REG_RESULT, rd);
    cmp_val(rd, 32'(m_res));
    $display("Arithmetic test done");
    for (int i = 0; i < 48; i++)
      run_jump(i % 3, 4'(i / 3), ofs[i % 4],
        (i % 5 == 0) ? 20'h00000 : (i % 5 == 1) ? 20'hFFFFE : 20'(rnd()));
    bus_rd(CFB_REG_PC, rd);
    cmp_val(rd, 32'(m_pc));
    bus_rd(8'h10, rd);
    cmp_val(rd, 32'h0000_0000);
    $display("Jump test done");
    @(posedge core_clk);
    irq_pending <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      m_sr = 16'h0035;
      bus_wr(CFB_REG_SR, {16'h0000, m_sr});
      i_mem.fetch(CFB_IRQ_ALLOW_OP, 1'b0, 16'(rnd()), 10'(rnd()), 0);
      #1;
      cmp_val(32'(sr), 32'(m_sr | CFB_IRQ_ALLOW_MASK));
      repeat (3) @(posedge core_clk);
      #1;
      cmp_bit(irq_take, 1'b0);
      bus_rd(CFB_REG_INFO, rd);
      cmp_val(rd, 32'h0000_0001);
      if (k == 0)
      begin
        i_mem.fetch(CFB_INC, 1'b0, 16'h0041, 10'h000, 0);
        #1;
        cmp_val(32'(res_data), 32'h0000_0042);
      end
      else
      begin
        @(posedge core_clk);
        other_retire <= 1'b1;
        @(posedge core_clk);
        other_retire <= 1'b0;
        #1;
      end
      cmp_bit(irq_take, 1'b1);
    end
    $display("Interrupt allow test done");
    close_out();
  end
endmodule : tb_top
